// *** core/slt_top.sv ***
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "slt_params.svh"

// What this block does
// RQ1: input-select high routes the first serial input to the reclocker.
// RQ2: input-select low routes the second serial input to the reclocker.
// RQ3: carrier-detect low means valid stream; high means invalid input.
// RQ4: input-select also picks the carrier-detect that feeds lock detection.
// RQ5: without equalizer, the outside drives both carrier-detects itself.
// RQ6: single-input use holds second data and its carrier-detect high.
// RQ7: master mode alternates reclocker rate between SD and HD while hunting.
// RQ8: slave mode rate comes only from the rate-select pin.
// RQ9: reclocker lock raises the internal PLL-locked flag to lock detection.
// RQ10: enable pin high drives loop-through; low puts both pins high impedance.
// RQ11: slave reclock-select high gives reclocked output, low gives buffered.
// RQ12: master drives reclock-select high and reclocks only after stream lock.
// RQ13: loop-through mutes whenever selected carrier-detect shows invalid input.
// RQ14: slave mutes when reclocked output chosen but lock is low.
// RQ15: lock never shown while selected carrier-detect is high.
// RQ16: converter builds 10 or 20 bit words, offered to both aligners together.
// RQ17: role pin high gives master mode, low gives slave mode.
// RQ18: four format pins are outputs in master mode, inputs in slave mode.
// RQ19: video or transport lock needs PLL lock and found sync words.
// RQ20: asynchronous control pins pass two flip-flops before use.

module slt_top
  import slt_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   reset_in,
  // avalon-mm slave
  input  wire logic [`SLT_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic      [31:0]            avs_readdata_out,
  output logic                        avs_waitrequest_out,
  // serial inputs and carrier detects
  input  wire logic                   serial_in_first_in,
  input  wire logic                   serial_in_second_in,
  input  wire logic                   signal_present_n_first_in,
  input  wire logic                   signal_present_n_second_in,
  input  wire logic                   input_choice_pin_in,
  input  wire logic                   loopthrough_enable_in,
  input  wire logic                   master_role_pin_in,
  // reclocker and aligner handshakes
  input  wire logic                   pll_locked_in,
  input  wire logic                   video_sync_found_in,
  input  wire logic                   transport_sync_found_in,
  // two-way format pins
  input  wire logic                   rate_select_in,
  output logic                        rate_select_out,
  output logic                        rate_select_oe_out,
  input  wire logic                   reclock_select_in,
  output logic                        reclock_select_out,
  output logic                        reclock_select_oe_out,
  input  wire logic                   video_bypass_pin_in,
  output logic                        video_bypass_pin_out,
  output logic                        video_bypass_pin_oe_out,
  input  wire logic                   transport_stream_pin_in,
  output logic                        transport_stream_pin_out,
  output logic                        transport_stream_pin_oe_out,
  // outputs
  output logic                        rate_ctrl_out,
  output logic                        locked_out,
  output logic                        signal_present_n_selected_out,
  output logic                        loopthrough_out_p_out,
  output logic                        loopthrough_out_n_out,
  output logic                        loopthrough_oe_out,
  output logic      [`SLT_WORD_W-1:0] word_out,
  output logic                        word_valid_out
);

  localparam int NPIN = 12;

  logic [NPIN-1:0]         pins_raw;
  logic [NPIN-1:0]         pins_s;
  logic                    data_first_s;
  logic                    data_second_s;
  logic                    cd_first_s;
  logic                    cd_second_s;
  logic                    choice_s;
  logic                    enable_s;
  logic                    master_s;
  logic                    pll_s;
  logic                    rate_pin_s;
  logic                    reclk_pin_s;
  logic                    video_pin_s;
  logic                    trans_pin_s;
  logic                    video_sync;
  logic                    trans_sync;
  logic                    sel_bit;
  logic                    cd_sel_n;
  logic                    sync_ok;
  logic                    locked_d;
  logic                    reclocked_sel;
  logic                    muted_d;
  logic                    retime_q;
  logic                    locked_q;
  logic                    muted_q;
  logic                    rate_hunt_q;
  logic [`SLT_CNT_W-1:0]   dwell_q;
  logic [2:0]              tries_q;
  slt_lock_state_t         state_q;
  logic [31:0]             ctrl_q;
  logic [31:0]             status_w;
  logic [31:0]             pins_w;
  logic                    req;
  logic                    dwell_done;

  function automatic logic [31:0] reg_read(input logic [`SLT_ADDR_W-1:0] a,
                                           input logic [31:0] c,
                                           input logic [31:0] s,
                                           input logic [31:0] p);
    unique case (a)
      `SLT_ADDR_CTRL:   reg_read = c;
      `SLT_ADDR_STATUS: reg_read = s;
      `SLT_ADDR_PINS:   reg_read = p;
      default:          reg_read = 32'h0000_0000;
    endcase
  endfunction

  assign pins_raw = {serial_in_first_in, serial_in_second_in, signal_present_n_first_in,
                     signal_present_n_second_in, input_choice_pin_in, loopthrough_enable_in,
                     master_role_pin_in, pll_locked_in, rate_select_in, reclock_select_in,
                     video_bypass_pin_in, transport_stream_pin_in};

  // carrier detects reset high so nothing looks valid before sampling
  slt_sync2 #(
    .W         (NPIN),
    .RESET_VAL (12'h300)
  ) u_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .d_in     (pins_raw),
    .q_out    (pins_s)
  ); // RQ20

  assign {data_first_s, data_second_s, cd_first_s, cd_second_s, choice_s, enable_s,
          master_s, pll_s, rate_pin_s, reclk_pin_s, video_pin_s, trans_pin_s} = pins_s;

  // aligner flags come from logic on this clock
  assign video_sync = video_sync_found_in;
  assign trans_sync = transport_sync_found_in;

  // 2x1 muxes for data and carrier detect
  assign sel_bit  = choice_s ? data_first_s : data_second_s; // RQ1 RQ2
  assign cd_sel_n = choice_s ? cd_first_s : cd_second_s;     // RQ4 RQ3

  // master: any sync word; slave: sync matching the configured format, or data-through
  assign sync_ok = master_s ? (video_sync | trans_sync)
                            : ((video_pin_s & video_sync) | (trans_pin_s & trans_sync) |
                               (!video_pin_s & !trans_pin_s)); // RQ19
  assign locked_d = !cd_sel_n && pll_s && sync_ok && (!master_s || state_q != SLT_ST_PLL); // RQ15 RQ9 RQ19

  assign reclocked_sel = master_s ? locked_q : reclk_pin_s; // RQ11 RQ12
  assign muted_d = cd_sel_n | (!master_s & reclk_pin_s & !locked_q) | ctrl_q[`SLT_CTRL_MUTE_BIT]; // RQ13 RQ14

  assign dwell_done = (dwell_q == `SLT_CNT_W'(`SLT_HUNT_CYCLES - 1));

  // lock detect: hunt over rates in master mode, then pll state with lock held low
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q     <= SLT_ST_IDLE;
      rate_hunt_q <= `SLT_RATE_HD;
      dwell_q     <= '0;
      tries_q     <= '0;
    end else if (cd_sel_n) begin
      state_q     <= SLT_ST_IDLE;
      rate_hunt_q <= `SLT_RATE_HD;
      dwell_q     <= '0;
      tries_q     <= '0;
    end else begin
      unique case (state_q)
        SLT_ST_IDLE: begin
          state_q <= SLT_ST_HUNT;
          dwell_q <= '0;
          tries_q <= '0;
        end
        SLT_ST_HUNT: begin
          if (locked_d) begin
            state_q <= SLT_ST_LOCK;
          end else if (dwell_done) begin
            dwell_q     <= '0;
            rate_hunt_q <= ~rate_hunt_q; // RQ7
            tries_q     <= tries_q + 1'b1;
            if (tries_q == `SLT_HUNT_TRIES - 1'b1) begin
              state_q <= SLT_ST_PLL;
            end
          end else begin
            dwell_q <= dwell_q + 1'b1;
          end
        end
        SLT_ST_PLL: begin
          if (!master_s) begin
            state_q <= SLT_ST_HUNT;
            tries_q <= '0;
          end
        end
        SLT_ST_LOCK: begin
          if (!locked_d) begin
            state_q <= SLT_ST_HUNT;
            dwell_q <= '0;
            tries_q <= '0;
          end
        end
      endcase
    end
  end

  // lock, mute and loop-through datapath
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      retime_q              <= 1'b0;
      locked_q              <= 1'b0;
      muted_q               <= 1'b1;
      loopthrough_out_p_out <= 1'b0;
      loopthrough_out_n_out <= 1'b1;
      loopthrough_oe_out    <= 1'b0;
    end else begin
      retime_q           <= sel_bit; // RQ1 RQ2
      locked_q           <= locked_d;
      muted_q            <= muted_d;
      loopthrough_oe_out <= enable_s; // RQ10
      if (muted_d) begin
        loopthrough_out_p_out <= 1'b0;
        loopthrough_out_n_out <= 1'b1;
      end else begin
        loopthrough_out_p_out <= reclocked_sel ? retime_q : sel_bit;  // RQ11 RQ12
        loopthrough_out_n_out <= reclocked_sel ? ~retime_q : ~sel_bit;
      end
    end
  end

  // format pins and reclocker rate
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rate_ctrl_out                 <= `SLT_RATE_HD;
      locked_out                    <= 1'b0;
      signal_present_n_selected_out <= 1'b1;
      rate_select_out               <= 1'b0;
      reclock_select_out            <= 1'b0;
      video_bypass_pin_out          <= 1'b0;
      transport_stream_pin_out      <= 1'b0;
      rate_select_oe_out            <= 1'b0;
      reclock_select_oe_out         <= 1'b0;
      video_bypass_pin_oe_out       <= 1'b0;
      transport_stream_pin_oe_out   <= 1'b0;
    end else begin
      rate_ctrl_out                 <= master_s ? rate_hunt_q : rate_pin_s; // RQ7 RQ8 RQ17
      locked_out                    <= locked_d; // RQ15
      signal_present_n_selected_out <= cd_sel_n;
      rate_select_out               <= rate_hunt_q;
      reclock_select_out            <= locked_d; // RQ12
      video_bypass_pin_out          <= locked_d & video_sync;
      transport_stream_pin_out      <= locked_d & trans_sync & !video_sync;
      rate_select_oe_out            <= master_s; // RQ18
      reclock_select_oe_out         <= master_s;
      video_bypass_pin_oe_out       <= master_s;
      transport_stream_pin_oe_out   <= master_s;
    end
  end

  slt_deser u_deser (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .bit_in         (retime_q),
    .wide_in        (ctrl_q[`SLT_CTRL_WIDE_BIT]),
    .word_out       (word_out),
    .word_valid_out (word_valid_out)
  ); // RQ16

  // register views
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`SLT_ST_PRESENT_BIT] = !cd_sel_n;
    status_w[`SLT_ST_LOCKED_BIT]  = locked_q;
    status_w[`SLT_ST_MASTER_BIT]  = master_s;
    status_w[`SLT_ST_RATE_BIT]    = rate_ctrl_out;
    status_w[`SLT_ST_RECLK_BIT]   = reclocked_sel;
    status_w[`SLT_ST_MUTED_BIT]   = muted_q;
    status_w[`SLT_ST_STATE_LSB +: 2] = state_q;
    status_w[`SLT_ST_TRIES_LSB +: 3] = tries_q;
    pins_w = 32'h0000_0000;
    pins_w[`SLT_PN_CHOICE_BIT] = choice_s;
    pins_w[`SLT_PN_ENABLE_BIT] = enable_s;
    pins_w[`SLT_PN_RECLK_BIT]  = reclk_pin_s;
    pins_w[`SLT_PN_RATE_BIT]   = rate_pin_s;
    pins_w[`SLT_PN_VIDEO_BIT]  = video_pin_s;
    pins_w[`SLT_PN_TRANS_BIT]  = trans_pin_s;
    pins_w[`SLT_PN_CD1_BIT]    = cd_first_s;
    pins_w[`SLT_PN_CD2_BIT]    = cd_second_s;
  end

  // avalon: wait one cycle, answer with waitrequest low for one cycle
  assign req = avs_read_in | avs_write_in;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= reg_read(avs_address_in, ctrl_q, status_w, pins_w);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_q <= `SLT_CTRL_RESET;
    end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == `SLT_ADDR_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_in[b]) begin
          ctrl_q[8*b +: 8] <= avs_writedata_in[8*b +: 8];
        end
      end
    end
  end

  sequence s_hunt_expire;
    master_s && !cd_sel_n && state_q == SLT_ST_HUNT && dwell_done && !locked_d;
  endsequence

  chk_first_input_route: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ1
    choice_s |=> retime_q == $past(data_first_s))
    else $error("first input not routed");

  chk_second_input_route: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ2
    !choice_s |=> retime_q == $past(data_second_s))
    else $error("second input not routed");

  chk_hunt_rate_toggle: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ7
    s_hunt_expire ##1 master_s |-> ##1 rate_ctrl_out != $past(rate_ctrl_out, 2))
    else $error("hunt did not alternate rate");

  chk_slave_rate_pin: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ8
    !master_s |=> rate_ctrl_out == $past(rate_pin_s))
    else $error("slave rate not from pin");

  chk_lock_needs_carrier: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ15
    $past(cd_sel_n) |-> !locked_out)
    else $error("lock shown without carrier");

  chk_lock_needs_pll: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ19
    locked_out |-> $past(pll_s) && $past(sync_ok))
    else $error("lock without pll and sync");

  chk_carrier_mute: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ13
    cd_sel_n |=> muted_q && !loopthrough_out_p_out && loopthrough_out_n_out)
    else $error("invalid input not muted");

  chk_slave_unlock_mute: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ14
    (!master_s && reclk_pin_s && !locked_q) |=> muted_q)
    else $error("slave reclocked unlocked not muted");

  chk_enable_hiz: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ10
    !enable_s |=> !loopthrough_oe_out)
    else $error("output driven while disabled");

  chk_master_pins_drive: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ18
    ##1 (rate_select_oe_out == $past(master_s)) && (reclock_select_oe_out == $past(master_s)))
    else $error("format pin direction wrong");

  // master: reclock pin high means reclocked loop-through, low means buffered
  chk_master_reclock_lock: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ12
    master_s && !muted_d |=> loopthrough_out_p_out ==
      ($past(reclock_select_out) ? $past(retime_q) : $past(sel_bit)))
    else $error("loop-through path disagrees with reclock pin");

endmodule

`default_nettype wire

// *** core/slt_params.svh ***
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH

// avalon register map, byte addresses
`define SLT_ADDR_W          4
`define SLT_ADDR_CTRL       4'h0
`define SLT_ADDR_STATUS     4'h4
`define SLT_ADDR_PINS       4'h8
`define SLT_CTRL_RESET      32'h0000_0000

// control fields
`define SLT_CTRL_WIDE_BIT   0
`define SLT_CTRL_MUTE_BIT   1

// status fields
`define SLT_ST_PRESENT_BIT  0
`define SLT_ST_LOCKED_BIT   1
`define SLT_ST_MASTER_BIT   2
`define SLT_ST_RATE_BIT     3
`define SLT_ST_RECLK_BIT    4
`define SLT_ST_MUTED_BIT    5
`define SLT_ST_STATE_LSB    6
`define SLT_ST_TRIES_LSB    8

// pin readback fields
`define SLT_PN_CHOICE_BIT   0
`define SLT_PN_ENABLE_BIT   1
`define SLT_PN_RECLK_BIT    2
`define SLT_PN_RATE_BIT     3
`define SLT_PN_VIDEO_BIT    4
`define SLT_PN_TRANS_BIT    5
`define SLT_PN_CD1_BIT      6
`define SLT_PN_CD2_BIT      7

// rate encoding: high selects the standard-definition rate
`define SLT_RATE_SD         1'b1
`define SLT_RATE_HD         1'b0

// hunt dwell per attempt
`define SLT_CLK_MHZ         20
`define SLT_HUNT_DWELL_US   100
`define SLT_HUNT_CYCLES     (`SLT_HUNT_DWELL_US * `SLT_CLK_MHZ)
`define SLT_HUNT_TRIES      3'd4
`define SLT_CNT_W           12

// word widths
`define SLT_WORD_W          20
`define SLT_NARROW_W        10
`define SLT_BITCNT_W        5

`endif

// *** core/slt_pkg.sv ***
package slt_pkg;

  typedef enum logic [1:0] {
    SLT_ST_IDLE = 2'b00,
    SLT_ST_HUNT = 2'b01,
    SLT_ST_PLL  = 2'b10,
    SLT_ST_LOCK = 2'b11
  } slt_lock_state_t;

endpackage

// *** core/slt_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none

module slt_sync2
  import slt_pkg::*;
#(
  parameter int         W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta_q <= RESET_VAL;
      q_out  <= RESET_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

`default_nettype wire

// *** core/slt_deser.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "slt_params.svh"

module slt_deser
  import slt_pkg::*;
(
  input  wire logic                    mclk_in,
  input  wire logic                    reset_in,
  input  wire logic                    bit_in,
  input  wire logic                    wide_in,
  output logic      [`SLT_WORD_W-1:0]  word_out,
  output logic                         word_valid_out
);

  logic [`SLT_WORD_W-1:0]   shift_q;
  logic [`SLT_BITCNT_W-1:0] cnt_q;
  logic [`SLT_BITCNT_W-1:0] last_cnt;
  logic [`SLT_WORD_W-1:0]   shift_d;

  assign last_cnt = wide_in ? `SLT_BITCNT_W'(`SLT_WORD_W - 1) : `SLT_BITCNT_W'(`SLT_NARROW_W - 1);
  assign shift_d  = {shift_q[`SLT_WORD_W-2:0], bit_in};

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      shift_q <= '0;
      cnt_q   <= '0;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= (cnt_q >= last_cnt) ? '0 : cnt_q + 1'b1;
    end
  end

  // one word per 10 or 20 bits, handed to both aligners at once
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      word_out       <= '0;
      word_valid_out <= 1'b0;
    end else begin
      word_valid_out <= (cnt_q >= last_cnt); // RQ16
      if (cnt_q >= last_cnt) begin
        word_out <= wide_in ? shift_d : {{(`SLT_WORD_W-`SLT_NARROW_W){1'b0}}, shift_d[`SLT_NARROW_W-1:0]}; // RQ16
      end
    end
  end

  sequence s_narrow_gap;
    word_valid_out ##1 (!word_valid_out)[*8];
  endsequence

  property p_narrow_period;
    @(posedge mclk_in) disable iff (reset_in)
      (word_valid_out && !wide_in && $stable(wide_in)) ##1 (!wide_in)[*8] ##1 !wide_in |-> ##1 word_valid_out;
  endproperty

  chk_narrow_word_period: assert property (p_narrow_period) // RQ16
    else $error("narrow word strobe not every 10 bits");

endmodule

`default_nettype wire

// *** tb/slt_eq_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module slt_eq_model (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic single_in,
  input  wire logic valid_first_in,
  input  wire logic valid_second_in,
  input  wire logic level_first_in,
  input  wire logic level_second_in,
  output logic      serial_first_out,
  output logic      serial_second_out,
  output logic      cd_n_first_out,
  output logic      cd_n_second_out
);
  logic toggle_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
    end
  end

  // no carrier: data wanders every cycle
  assign cd_n_first_out    = ~valid_first_in;
  assign cd_n_second_out   = single_in | ~valid_second_in;
  assign serial_first_out  = valid_first_in ? level_first_in : toggle_q;
  assign serial_second_out = single_in | (valid_second_in ? level_second_in : toggle_q);
endmodule

`default_nettype wire

// *** tb/tb_serial_input_select_loopthrough_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "slt_params.svh"

module tb_serial_input_select_loopthrough_ctrl;
  logic mclk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [3:0] avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic serial_in_first_in, serial_in_second_in, signal_present_n_first_in, signal_present_n_second_in;
  logic input_choice_pin_in, loopthrough_enable_in, master_role_pin_in, pll_locked_in;
  logic video_sync_found_in, transport_sync_found_in;
  logic rate_select_in, rate_select_out, rate_select_oe_out, reclock_select_in, reclock_select_out;
  logic reclock_select_oe_out, video_bypass_pin_in, video_bypass_pin_out, video_bypass_pin_oe_out;
  logic transport_stream_pin_in, transport_stream_pin_out, transport_stream_pin_oe_out;
  logic rate_ctrl_out, locked_out, signal_present_n_selected_out, loopthrough_out_p_out;
  logic loopthrough_out_n_out, loopthrough_oe_out, word_valid_out;
  logic [19:0] word_out;
  logic rs_drv, rc_drv, single, v1, v2, l1, l2;
  int err_total, n_compared, cycles;

  // two-way pins: whoever enables drives the wire
  assign rate_select_in          = rate_select_oe_out ? rate_select_out : rs_drv;
  assign reclock_select_in       = reclock_select_oe_out ? reclock_select_out : rc_drv;
  assign video_bypass_pin_in     = video_bypass_pin_oe_out ? video_bypass_pin_out : 1'b0;
  assign transport_stream_pin_in = transport_stream_pin_oe_out ? transport_stream_pin_out : 1'b0;

  slt_top u_dut (.*);

  slt_eq_model u_eq (
    .mclk_in           (mclk_in),
    .reset_in          (reset_in),
    .single_in         (single),
    .valid_first_in    (v1),
    .valid_second_in   (v2),
    .level_first_in    (l1),
    .level_second_in   (l2),
    .serial_first_out  (serial_in_first_in),
    .serial_second_out (serial_in_second_in),
    .cd_n_first_out    (signal_present_n_first_in),
    .cd_n_second_out   (signal_present_n_second_in)
  );

  always #25 mclk_in = ~mclk_in;

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    avs_writedata_in <= wd;
    @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge mclk_in);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  // pins change together, then wait past sync and output flop
  task automatic link(input logic role, ch, en, rc, pll, f1, vs);
    @(posedge mclk_in);
    master_role_pin_in <= role;
    input_choice_pin_in <= ch;
    loopthrough_enable_in <= en;
    rc_drv <= rc;
    pll_locked_in <= pll;
    v1 <= f1;
    video_sync_found_in <= vs;
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic t_select();
    link(0, 1, 1, 0, 0, 1, 0);
    chk(signal_present_n_selected_out, 0);
    chk({loopthrough_out_p_out, loopthrough_out_n_out}, 2'b10);
    chk({rate_select_oe_out, reclock_select_oe_out, video_bypass_pin_oe_out}, 0);
    link(0, 0, 1, 0, 0, 1, 0);
    chk({signal_present_n_selected_out, loopthrough_out_p_out}, 2'b00);
    link(0, 1, 1, 0, 0, 0, 0);
    chk(signal_present_n_selected_out, 1);
    chk({loopthrough_out_p_out, loopthrough_out_n_out}, 2'b01);
    single <= 1'b1;
    link(0, 0, 1, 0, 0, 1, 0);
    chk({signal_present_n_selected_out, loopthrough_out_n_out}, 2'b11);
    single <= 1'b0;
    link(0, 1, 0, 0, 0, 1, 0);
    chk(loopthrough_oe_out, 0);
    link(0, 1, 1, 0, 0, 1, 0);
    chk(loopthrough_oe_out, 1);
  endtask

  task automatic t_slave();
    rs_drv <= 1'b1;
    link(0, 1, 1, 1, 0, 1, 0);
    chk(rate_ctrl_out, `SLT_RATE_SD);
    chk({locked_out, loopthrough_out_p_out, loopthrough_out_n_out}, 3'b001);
    rs_drv <= 1'b0;
    link(0, 1, 1, 1, 1, 1, 0);
    chk(rate_ctrl_out, `SLT_RATE_HD);
    chk({locked_out, loopthrough_out_p_out, loopthrough_out_n_out}, 3'b110);
    link(0, 1, 1, 1, 1, 0, 0);
    chk({locked_out, loopthrough_out_n_out}, 2'b01);
  endtask

  task automatic t_master();
    int i;
    link(1, 1, 1, 0, 0, 0, 0);
    link(1, 1, 1, 0, 0, 1, 0);
    chk({rate_select_oe_out, reclock_select_oe_out, transport_stream_pin_oe_out}, 3'h7);
    chk({reclock_select_out, rate_ctrl_out, rate_select_out}, 3'b000);
    for (i = 0; i < 2100 && rate_ctrl_out !== 1'b1; i++) @(posedge mclk_in);
    chk({rate_ctrl_out, rate_select_out}, {`SLT_RATE_SD, `SLT_RATE_SD});
    // three more attempts, then pll lock state with lock held low
    repeat (6100) @(posedge mclk_in);
    av(0, `SLT_ADDR_STATUS, 0);
    chk(rd, 32'h0000_0485);
    link(1, 1, 1, 0, 0, 0, 0);
    link(1, 1, 1, 0, 1, 1, 0);
    chk(locked_out, 0);
    video_sync_found_in <= 1'b1;
    for (i = 0; i < 9000 && locked_out !== 1'b1; i++) @(posedge mclk_in);
    repeat (2) @(posedge mclk_in);
    chk({locked_out, reclock_select_out, video_bypass_pin_out, transport_stream_pin_out}, 4'he);
    chk({loopthrough_out_p_out, loopthrough_out_n_out}, 2'b10);
    av(0, `SLT_ADDR_STATUS, 0);
    chk(rd & 32'h0000_0006, 32'h0000_0006);
    link(1, 1, 1, 0, 1, 0, 1);
    chk({locked_out, loopthrough_out_p_out, loopthrough_out_n_out}, 3'b001);
  endtask

  task automatic words(input logic [19:0] exp);
    int i;
    int k;
    k = 0;
    for (i = 0; i < 200 && k < 3; i++) begin
      @(posedge mclk_in);
      if (word_valid_out === 1'b1) begin
        k++;
        if (k == 3) chk(word_out, exp);
      end
    end
    chk(k, 3);
  endtask

  task automatic t_words();
    link(0, 1, 1, 0, 0, 1, 0);
    av(0, 4'hc, 32'h0000_0000);
    chk(rd, 0);
    av(1, `SLT_ADDR_CTRL, 32'h0000_0001);
    av(0, `SLT_ADDR_CTRL, 0);
    chk(rd, 32'h0000_0001);
    repeat (30) @(posedge mclk_in);
    words(20'hfffff);
    av(1, `SLT_ADDR_CTRL, 32'h0000_0000);
    repeat (30) @(posedge mclk_in);
    words(20'h003ff);
  endtask

  initial begin
    {mclk_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    avs_byteenable_in = 4'hf;
    {input_choice_pin_in, loopthrough_enable_in, master_role_pin_in, pll_locked_in} = '0;
    {video_sync_found_in, transport_sync_found_in, rs_drv, rc_drv, single} = '0;
    {v1, v2, l1, l2} = 4'b1110;
    err_total = 0;
    n_compared = 0;
    cycles = 0;
    reset_in = 1'b1;
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_select();
    t_slave();
    t_words();
    t_master();
    complete_run();
  end
endmodule

`default_nettype wire
